// [hw/rx_lock_select_link_fault.v]
// Purpose: per-channel lock source select, input select and link fault
// Assumes: all pin inputs are asynchronous to clk
// Notes:   analog detectors deliver amplitudeOk and rateInRange levels
//          fault output is combinational, detectors reach it through two flip-flops
//
// Behaviour
// - check-enable high: level, range, density decide source
// - any deciding check failing locks loop to training clock
// - density fails: no transition in 60 bits
// - check-enable low: only range check decides
// - local-clock pin low: train, fault asserted
// - local-clock pin high: recover on selected input
// - three-level rate select sets loop range, static
// - input select high primary, low secondary
// - fault low on any of six conditions
// - strobe writes data byte into addressed latch
// - reset returns machines, counters, latches to initial
`timescale 1ns/10ps
`include "rx_lock_defines.vh"

module rx_lock_select_link_fault #(
   parameter CHANNELS = 4
) (
   // clock and reset
   input  wire                  clk,
   input  wire                  rst,
   // avalon-mm slave
   input  wire [7:0]            address,
   input  wire                  read,
   input  wire                  write,
   input  wire [31:0]           writedata,
   output reg  [31:0]           readdata,
   output wire                  waitrequest,
   output wire                  irq,
   // global pins
   input  wire                  lockCheckEnable,
   // per-channel pins
   input  wire [CHANNELS-1:0]   forceLocalClockN,
   input  wire [CHANNELS-1:0]   inputPortSelect,
   input  wire [2*CHANNELS-1:0] rateRangeSelect,
   input  wire [CHANNELS-1:0]   primarySerialInput,
   input  wire [CHANNELS-1:0]   secondarySerialInput,
   input  wire [CHANNELS-1:0]   trainingClock,
   input  wire [CHANNELS-1:0]   amplitudeOk,
   input  wire [CHANNELS-1:0]   rateInRange,
   // configuration port
   input  wire                  configWriteStrobe,
   input  wire [3:0]            configAddr,
   input  wire [7:0]            configData,
   // recovery loop controls
   output wire [CHANNELS-1:0]   lockToTraining,
   output reg  [CHANNELS-1:0]   selectedSerial,
   output reg  [2*CHANNELS-1:0] recoveryRange,
   output wire [2*CHANNELS-1:0] amplitudeTripSelect,
   output wire [CHANNELS-1:0]   linkFaultN
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam SW = 7 * CHANNELS + 1;

   reg  [SW-1:0] pinMeta_q;
   reg  [SW-1:0] pinSync_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pinMeta_q <= {SW{1'b0}};
         pinSync_q <= {SW{1'b0}};
      end else begin
         pinMeta_q <= {lockCheckEnable, forceLocalClockN, inputPortSelect,
                       rateRangeSelect, primarySerialInput,
                       secondarySerialInput, trainingClock};
         pinSync_q <= pinMeta_q;
      end
   end

   // a second pair for the analog detector levels
   reg  [2*CHANNELS-1:0] detMeta_q;
   reg  [2*CHANNELS-1:0] detSync_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         detMeta_q <= {2*CHANNELS{1'b0}};
         detSync_q <= {2*CHANNELS{1'b0}};
      end else begin
         detMeta_q <= {amplitudeOk, rateInRange};
         detSync_q <= detMeta_q;
      end
   end

   wire                  checkEn = pinSync_q[SW-1];
   wire [CHANNELS-1:0]   ulcN    = pinSync_q[7*CHANNELS-1 -: CHANNELS];
   wire [CHANNELS-1:0]   inSel   = pinSync_q[6*CHANNELS-1 -: CHANNELS];
   wire [2*CHANNELS-1:0] rateSel = pinSync_q[5*CHANNELS-1 -: 2*CHANNELS];
   wire [CHANNELS-1:0]   priIn   = pinSync_q[3*CHANNELS-1 -: CHANNELS];
   wire [CHANNELS-1:0]   secIn   = pinSync_q[2*CHANNELS-1 -: CHANNELS];
   wire [CHANNELS-1:0]   trgIn   = pinSync_q[CHANNELS-1:0];
   wire [CHANNELS-1:0]   ampOk   = detSync_q[2*CHANNELS-1 -: CHANNELS];
   wire [CHANNELS-1:0]   rangeOk = detSync_q[CHANNELS-1:0];

   // ----------------------------------------
   // configuration latches
   // ----------------------------------------
   wire [127:0] latchFlat;

   config_latch_file u_latches (
      .clk               (clk),
      .rst               (rst),
      .configWriteStrobe (configWriteStrobe),
      .configAddr        (configAddr),
      .configData        (configData),
      .latchFlat         (latchFlat)
   );

   wire [7:0] chanDisableByte = latchFlat[`LATCH_CHAN_DISABLE*8 +: 8];
   wire [7:0] ampTripByte     = latchFlat[`LATCH_AMP_TRIP*8 +: 8];
   // limitation: the disable byte covers at most eight channels
   wire [CHANNELS-1:0] chanDisable = chanDisableByte[CHANNELS-1:0];

   // ----------------------------------------
   // per-channel lock source and fault
   // ----------------------------------------
   wire [CHANNELS-1:0] densityFail;
   wire [CHANNELS-1:0] trainingAbsent;
   wire [CHANNELS-1:0] muxedBit;
   wire [CHANNELS-1:0] checkFail;

   genvar c;
   generate
      for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
         assign muxedBit[c] = inSel[c] ? priIn[c] : secIn[c];

         transition_density_check u_check (
            .clk            (clk),
            .rst            (rst),
            .serialBit      (muxedBit[c]),
            .trainingClock  (trgIn[c]),
            .densityFail    (densityFail[c]),
            .trainingAbsent (trainingAbsent[c])
         );

         // all three checks with checking on, else range alone
         assign checkFail[c] = checkEn ?
                               (~rangeOk[c] | ~ampOk[c] | densityFail[c])
                             : ~rangeOk[c];

         // follows checks live, so it returns as soon as they are valid
         assign lockToTraining[c] = ~ulcN[c] | checkFail[c];

         // combinational on purpose: no dependence on the recovered clock
         assign linkFaultN[c] = ~(~rangeOk[c] | ~ampOk[c] | densityFail[c]
                                  | chanDisable[c] | ~ulcN[c]
                                  | trainingAbsent[c]);

         assign amplitudeTripSelect[2*c +: 2] = ampTripByte[2*c +: 2];
      end
   endgenerate

   // ----------------------------------------
   // data path registers
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         selectedSerial <= {CHANNELS{1'b0}};
         recoveryRange  <= {2*CHANNELS{1'b0}};
      end else begin
         selectedSerial <= muxedBit;
         // range follows the pin; the pin is expected static
         recoveryRange  <= rateSel;
      end
   end

   // ----------------------------------------
   // interrupt events
   // ----------------------------------------
   reg  [CHANNELS-1:0]   faultLast_q;
   reg  [CHANNELS-1:0]   trainLast_q;
   reg  [2*CHANNELS-1:0] irqStatus_q;
   reg  [2*CHANNELS-1:0] irqMask_q;
   wire [CHANNELS-1:0]   faultNow;
   wire [CHANNELS-1:0]   faultRise;
   wire [CHANNELS-1:0]   trainRise;
   wire [2*CHANNELS-1:0] events;
   wire [2*CHANNELS-1:0] clearBits;
   wire [2*CHANNELS-1:0] statusNext;

   assign faultNow = ~linkFaultN;

   generate
      for (c = 0; c < CHANNELS; c = c + 1) begin : g_event
         // rising edges only: a fault that stays up raises one event
         assign faultRise[c] = faultNow[c] & ~faultLast_q[c];
         assign trainRise[c] = lockToTraining[c] & ~trainLast_q[c];
      end
   endgenerate

   assign events = {trainRise, faultRise};
   // a new event wins over a clear in the same cycle
   assign statusNext = (irqStatus_q & ~clearBits) | events;

   // ----------------------------------------
   // avalon slave: one wait state per access
   // ----------------------------------------
   reg        ack_q;
   wire       access;
   wire       writeAck;
   wire       hitLive;
   wire       hitStatus;
   wire       hitMask;
   wire       hitLatch;
   wire [3:0] latchIndex;

   assign access      = read | write;
   assign writeAck    = write & ack_q;
   // answer in the second cycle, readdata is loaded by then
   assign waitrequest = access & ~ack_q;

   // unmapped addresses still answer, reading zero
   assign hitLive    = (address == `REG_LIVE_STATUS);
   assign hitStatus  = (address == `REG_IRQ_STATUS);
   assign hitMask    = (address == `REG_IRQ_MASK);
   assign hitLatch   = (address >= `REG_LATCH_BASE) && (address <= `REG_LATCH_LAST)
                       && (address[1:0] == 2'h0);
   assign latchIndex = address[5:2];

   assign clearBits = (writeAck && hitStatus) ? writedata[2*CHANNELS-1:0]
                                              : {2*CHANNELS{1'b0}};
   // level output: high until software clears or masks
   assign irq = |(irqStatus_q & irqMask_q);

   // ----------------------------------------
   // edge history and status
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         // reset shows fault and training lock: history starts high
         faultLast_q <= {CHANNELS{1'b1}};
         trainLast_q <= {CHANNELS{1'b1}};
      end else begin
         faultLast_q <= faultNow;
         trainLast_q <= lockToTraining;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irqStatus_q <= {2*CHANNELS{1'b0}};
      end else begin
         irqStatus_q <= statusNext;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irqMask_q <= {2*CHANNELS{1'b0}};
      end else if (writeAck && hitMask) begin
         irqMask_q <= writedata[2*CHANNELS-1:0];
      end
   end

   // wait, answer, then free for the next access
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access & ~ack_q;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg [31:0] readNext;

   always @* begin
      readNext = 32'h00000000;
      if (hitLive) begin
         readNext[`LIVE_TRAIN_LSB  +: CHANNELS] = lockToTraining;
         readNext[`LIVE_FAULT_LSB  +: CHANNELS] = ~linkFaultN;
         readNext[`LIVE_DENS_LSB   +: CHANNELS] = densityFail;
         readNext[`LIVE_TRGABS_LSB +: CHANNELS] = trainingAbsent;
      end else if (hitStatus) begin
         readNext[2*CHANNELS-1:0] = irqStatus_q;
      end else if (hitMask) begin
         readNext[2*CHANNELS-1:0] = irqMask_q;
      end else if (hitLatch) begin
         readNext[7:0] = latchFlat[latchIndex*8 +: 8];
      end
   end

   // loaded in the wait cycle, held until the next read
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (read & ~ack_q) begin
         readdata <= readNext;
      end
   end

endmodule // rx_lock_select_link_fault

// [hw/rx_lock_defines.vh]
// Purpose: shared constants for the receive lock-select and link-fault block
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes:   all timing counts are in 100 MHz clock cycles
`ifndef RX_LOCK_DEFINES_VH
`define RX_LOCK_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_LIVE_STATUS   8'h00
`define REG_IRQ_STATUS    8'h04
`define REG_IRQ_MASK      8'h08
`define REG_LATCH_BASE    8'h40
`define REG_LATCH_LAST    8'h7c

// ----------------------------------------
// reset values
// ----------------------------------------
`define IRQ_MASK_RESET    8'h00
`define LATCH_RESET       8'h00

// ----------------------------------------
// configuration latch map
// ----------------------------------------
`define LATCH_CHAN_DISABLE 4'h0
`define LATCH_AMP_TRIP     4'h1

// ----------------------------------------
// live status field positions
// ----------------------------------------
`define LIVE_TRAIN_LSB    0
`define LIVE_FAULT_LSB    4
`define LIVE_DENS_LSB     8
`define LIVE_TRGABS_LSB   12

// ----------------------------------------
// rate range codes (three-level pin)
// ----------------------------------------
`define RANGE_LOW         2'h0
`define RANGE_MID         2'h1
`define RANGE_HIGH        2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define DENSITY_WINDOW_BITS 60
`define TRG_ABSENT_CYCLES   16

`endif

// [hw/transition_density_check.v]
// Purpose: per-channel transition density and training clock watchdogs
// Assumes: serial bit and training clock already pass two flip-flops
// Notes:   one sample per clock counts as one received bit
`timescale 1ns/10ps
`include "rx_lock_defines.vh"

module transition_density_check #(
   parameter WINDOW   = `DENSITY_WINDOW_BITS,
   parameter TRG_WAIT = `TRG_ABSENT_CYCLES
) (
   // clock and reset
   input  wire clk,
   input  wire rst,
   // synchronised inputs
   input  wire serialBit,
   input  wire trainingClock,
   // results
   output reg  densityFail,
   output reg  trainingAbsent
);

   // ----------------------------------------
   // density: run of bits without transition
   // ----------------------------------------
   reg       lastBit_q;
   reg [6:0] runLen_q;
   reg       lastTrg_q;
   reg [7:0] trgIdle_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lastBit_q      <= 1'b0;
         runLen_q       <= 7'h00;
         densityFail    <= 1'b1;
         lastTrg_q      <= 1'b0;
         trgIdle_q      <= 8'h00;
         trainingAbsent <= 1'b1;
      end else begin
         lastBit_q <= serialBit;
         // 60 bits with no edge means 59 equal neighbours
         if (serialBit != lastBit_q) begin
            runLen_q    <= 7'h00;
            densityFail <= 1'b0;
         end else if (runLen_q < WINDOW - 2) begin
            runLen_q    <= runLen_q + 7'h01;
         end else begin
            densityFail <= 1'b1;
         end
         lastTrg_q <= trainingClock;
         if (trainingClock != lastTrg_q) begin
            trgIdle_q      <= 8'h00;
            trainingAbsent <= 1'b0;
         end else if (trgIdle_q < TRG_WAIT - 1) begin
            trgIdle_q      <= trgIdle_q + 8'h01;
         end else begin
            trainingAbsent <= 1'b1;
         end
      end
   end

endmodule // transition_density_check

// [hw/config_latch_file.v]
// Purpose: sixteen 8-bit configuration latches written by an async strobe
// Assumes: strobe, address and data arrive from pins, unsynchronised
// Notes:   address and data must be stable around the strobe rising edge
`timescale 1ns/10ps
`include "rx_lock_defines.vh"

module config_latch_file (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // pin side
   input  wire        configWriteStrobe,
   input  wire [3:0]  configAddr,
   input  wire [7:0]  configData,
   // readback
   output wire [127:0] latchFlat
);

   // ----------------------------------------
   // synchronisers and strobe edge
   // ----------------------------------------
   reg [12:0] meta_q;
   reg [12:0] sync_q;
   reg        strobeLast_q;
   reg [7:0]  latch_q [0:15];
   wire       writeEdge = sync_q[12] & ~strobeLast_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q       <= 13'h0000;
         sync_q       <= 13'h0000;
         strobeLast_q <= 1'b0;
      end else begin
         meta_q       <= {configWriteStrobe, configAddr, configData};
         sync_q       <= meta_q;
         strobeLast_q <= sync_q[12];
      end
   end

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_latch
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               latch_q[i] <= `LATCH_RESET;
            end else if (writeEdge && sync_q[11:8] == i) begin
               latch_q[i] <= sync_q[7:0];
            end
         end
         assign latchFlat[i*8 +: 8] = latch_q[i];
      end
   endgenerate

endmodule // config_latch_file

// [verification/rx_lock_props.sv]
// Purpose: port-level checker for lock select, link fault and bus wait
// Assumes: pins held 4 clocks before a relation applies (sync latency)
// Notes:   settle counter masks the synchroniser fill after reset
`timescale 1ns/10ps
module rx_lock_props #(
   parameter CHANNELS = 4
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // bus
   input wire logic                  read,
   input wire logic                  write,
   input wire logic                  waitrequest,
   // pins
   input wire logic                  lockCheckEnable,
   input wire logic [CHANNELS-1:0]   forceLocalClockN,
   input wire logic [2*CHANNELS-1:0] rateRangeSelect,
   input wire logic [CHANNELS-1:0]   amplitudeOk,
   input wire logic [CHANNELS-1:0]   rateInRange,
   // outputs
   input wire logic [CHANNELS-1:0]   lockToTraining,
   input wire logic [2*CHANNELS-1:0] recoveryRange,
   input wire logic [CHANNELS-1:0]   linkFaultN
);
   logic [2:0] settle_q;
   always @(posedge clk or posedge rst) begin
      if (rst) settle_q <= 3'h0;
      else if (settle_q != 3'h7) settle_q <= settle_q + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_ulc;
      (!forceLocalClockN[0])[*4] |-> lockToTraining[0] && !linkFaultN[0];
   endproperty
   a_ulc: assert property (p_ulc) else $error("local clock pin low not obeyed");
   property p_cover;
      (lockToTraining & linkFaultN) == '0;
   endproperty
   a_cover: assert property (p_cover) else $error("training lock without fault");
   property p_en_low;
      (settle_q == 3'h7 && !lockCheckEnable && &rateInRange && &forceLocalClockN)[*4]
         |-> lockToTraining == '0;
   endproperty
   a_en_low: assert property (p_en_low) else $error("checks off yet locked");
   property p_amp_lock;
      (settle_q == 3'h7 && lockCheckEnable && !amplitudeOk[1])[*4] |-> lockToTraining[1];
   endproperty
   a_amp_lock: assert property (p_amp_lock) else $error("low level not locked");
   property p_amp_fault;
      (!amplitudeOk[1])[*4] |-> !linkFaultN[1];
   endproperty
   a_amp_fault: assert property (p_amp_fault) else $error("low level no fault");
   property p_rng_low;
      (!rateInRange[1])[*4] |-> lockToTraining[1] && !linkFaultN[1];
   endproperty
   a_rng_low: assert property (p_rng_low) else $error("out of range ignored");
   property p_range;
      (settle_q == 3'h7 && $stable(rateRangeSelect))[*4] |-> recoveryRange == rateRangeSelect;
   endproperty
   a_range: assert property (p_range) else $error("loop range not applied");
   property p_wait;
      $rose(read || write) |-> waitrequest ##1 !waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state count wrong");
endmodule // rx_lock_props

// [verification/serial_link_source.sv]
// Purpose: far-side model: serial source and training clock
// Assumes: one serial bit per clk
// Notes:   secondary is sparse on purpose, one edge per 80 bits
`timescale 1ns/10ps
module serial_link_source (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic [3:0] trainRun,
   // serial side
   output logic      [3:0] primarySerialInput,
   output logic      [3:0] secondarySerialInput,
   output logic      [3:0] trainingClock
);
   logic [6:0] slow_q;
   logic [1:0] div_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         primarySerialInput   <= 4'h0;
         secondarySerialInput <= 4'h0;
         trainingClock        <= 4'h0;
         slow_q               <= 7'h00;
         div_q                <= 2'h0;
      end else begin
         primarySerialInput <= ~primarySerialInput;
         slow_q <= (slow_q == 7'h4f) ? 7'h00 : slow_q + 7'h01;
         if (slow_q == 7'h4f) secondarySerialInput <= ~secondarySerialInput;
         div_q <= div_q + 2'h1;
         // stopped clock stands still, no free run
         if (div_q == 2'h3) trainingClock <= trainingClock ^ trainRun;
      end
   end
endmodule // serial_link_source

// [verification/testbench.sv]
// Purpose: self-checking bench for lock select and link fault
// Assumes: pins settle within 8 clocks through synchronisers
// Notes:   partner drives serial bits and training clocks
`timescale 1ns/10ps
`include "rx_lock_defines.vh"
module testbench;
   logic        clk, rst, read, write, en, strobe;
   logic [7:0]  address, rate, cfgData;
   logic [31:0] writedata, rd;
   logic [3:0]  fN, inSel, amp, rng, trainRun, cfgAddr;
   wire  [31:0] readdata;
   wire         waitrequest, irq;
   wire  [3:0]  prim, sec, trg, lock, selSer, faultN;
   wire  [7:0]  recRange, ampTrip;
   int          err_total, cmp_count, cycles, i;
   rx_lock_select_link_fault #(.CHANNELS(4)) dut (.clk(clk), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .lockCheckEnable(en), .forceLocalClockN(fN),
      .inputPortSelect(inSel), .rateRangeSelect(rate), .primarySerialInput(prim),
      .secondarySerialInput(sec), .trainingClock(trg), .amplitudeOk(amp),
      .rateInRange(rng), .configWriteStrobe(strobe), .configAddr(cfgAddr),
      .configData(cfgData), .lockToTraining(lock), .selectedSerial(selSer),
      .recoveryRange(recRange), .amplitudeTripSelect(ampTrip), .linkFaultN(faultN));
   serial_link_source partner (.clk(clk), .rst(rst), .trainRun(trainRun),
      .primarySerialInput(prim), .secondarySerialInput(sec), .trainingClock(trg));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         summarize();
      end
   end
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // holds the request until the rising edge that sees waitrequest low
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      // settled value before an edge is what that edge samples
      @(negedge clk);
      while (waitrequest !== 1'b0) @(negedge clk);
      @(posedge clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task cfg(input logic [3:0] a, input logic [7:0] d);
      cfgAddr <= a;
      cfgData <= d;
      tick(4);
      strobe <= 1'b1;
      tick(4);
      strobe <= 1'b0;
      tick(6);
   endtask
   task t_regs;
      bus(0, `REG_IRQ_MASK, 0);
      chk("mask reset", rd, 32'h0);
      bus(0, `REG_LATCH_BASE, 0);
      chk("latch reset", rd, 32'h0);
      bus(0, `REG_IRQ_STATUS, 0);
      chk("no event after reset", rd, 32'h0);
      bus(1, 8'h30, 32'h5a);
      bus(0, 8'h30, 0);
      chk("unmapped", rd, 32'h0);
      chk("good lock", lock, 4'h0);
      $display("regs done");
   endtask
   task t_ulc;
      fN <= 4'he;
      tick(8);
      chk("ulc low", {lock[0], faultN[0]}, 2'b10);
      fN <= 4'hf;
      tick(8);
      chk("ulc high", {lock[0], faultN[0]}, 2'b01);
      $display("ulc done");
   endtask
   task t_checks;
      amp <= 4'hd;
      tick(8);
      chk("amp lock", {lock[1], faultN[1]}, 2'b10);
      en <= 1'b0;
      tick(8);
      chk("en low amp", {lock[1], faultN[1]}, 2'b00);
      rng <= 4'hd;
      tick(8);
      chk("en low rng", {lock[1], faultN[1]}, 2'b10);
      amp <= 4'hf;
      rng <= 4'hf;
      en <= 1'b1;
      tick(8);
      chk("recover", {lock[1], faultN[1]}, 2'b01);
      $display("checks done");
   endtask
   // counts changes of a selected bit over 21 settled samples
   task toggles(input int ch, output int tg);
      logic last;
      tg = 0;
      @(negedge clk);
      last = selSer[ch];
      repeat (20) begin
         @(negedge clk);
         tg += (selSer[ch] != last);
         last = selSer[ch];
      end
      @(posedge clk);
   endtask
   task t_density;
      logic hit;
      int   tg;
      hit = 1'b0;
      inSel <= 4'hb;
      for (i = 0; i < 200 && !hit; i++) begin
         tick(1);
         hit = lock[2] & !faultN[2];
      end
      chk("sparse fails", hit, 1'b1);
      toggles(2, tg);
      chk("sel secondary", tg > 1, 1'b0);
      inSel <= 4'hf;
      tick(8);
      toggles(2, tg);
      chk("sel primary", tg, 20);
      hit = 1'b0;
      for (i = 0; i < 100; i++) begin
         tick(1);
         hit = hit | lock[2];
      end
      chk("dense passes", hit, 1'b0);
      $display("density done");
   endtask
   task t_trg;
      trainRun <= 4'h7;
      tick(40);
      chk("trg absent", {lock[3], faultN[3]}, 2'b00);
      trainRun <= 4'hf;
      tick(40);
      chk("trg back", faultN[3], 1'b1);
      $display("training done");
   endtask
   task t_cfg;
      cfg(`LATCH_CHAN_DISABLE, 8'h08);
      chk("disabled", {lock[3], faultN[3]}, 2'b00);
      bus(0, `REG_LATCH_BASE, 0);
      chk("latch0", rd, 32'h08);
      cfg(`LATCH_AMP_TRIP, 8'h1b);
      chk("trip", ampTrip, 8'h1b);
      cfg(4'h5, 8'ha5);
      bus(0, 8'h54, 0);
      chk("latch5", rd, 32'ha5);
      cfg(`LATCH_CHAN_DISABLE, 8'h00);
      chk("enabled", faultN[3], 1'b1);
      $display("config done");
   endtask
   task t_irq;
      bus(1, `REG_IRQ_STATUS, 32'hff);
      fN <= 4'he;
      tick(8);
      chk("masked", irq, 1'b0);
      bus(1, `REG_IRQ_MASK, 32'h1);
      chk("irq on", irq, 1'b1);
      bus(0, `REG_IRQ_STATUS, 0);
      chk("status", rd[0], 1'b1);
      fN <= 4'hf;
      tick(8);
      bus(1, `REG_IRQ_STATUS, 32'h1);
      chk("cleared", irq, 1'b0);
      bus(1, `REG_IRQ_MASK, 32'h0);
      $display("irq done");
   endtask
   task t_range;
      logic [1:0] codes [3];
      codes = '{`RANGE_LOW, `RANGE_MID, `RANGE_HIGH};
      for (i = 0; i < 3; i++) begin
         rate <= {4{codes[i]}};
         tick(8);
         chk("range", recRange, {4{codes[i]}});
      end
      $display("range done");
   endtask
   task t_reset;
      bus(1, `REG_IRQ_MASK, 32'h3);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(20);
      bus(0, `REG_IRQ_MASK, 0);
      chk("mask after reset", rd, 32'h0);
      bus(0, 8'h54, 0);
      chk("latch5 after reset", rd, 32'h0);
      chk("trip after reset", ampTrip, 8'h0);
      bus(0, `REG_IRQ_STATUS, 0);
      chk("status after reset", rd, 32'h0);
      $display("reset done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {clk, read, write, strobe, address, writedata, cfgAddr, cfgData, rate} = '0;
      {rst, en, fN, inSel, amp, rng, trainRun} = '1;
      {err_total, cmp_count, cycles} = '0;
      tick(5);
      rst <= 1'b0;
      tick(40);
      t_regs();
      t_ulc();
      t_checks();
      t_density();
      t_trg();
      t_cfg();
      t_irq();
      t_range();
      t_reset();
      summarize();
   end
endmodule // testbench
bind rx_lock_select_link_fault rx_lock_props #(.CHANNELS(CHANNELS)) props (.clk(clk),
   .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
   .lockCheckEnable(lockCheckEnable), .forceLocalClockN(forceLocalClockN),
   .rateRangeSelect(rateRangeSelect), .amplitudeOk(amplitudeOk), .rateInRange(rateInRange),
   .lockToTraining(lockToTraining), .recoveryRange(recoveryRange), .linkFaultN(linkFaultN));
